// ### verilog/adc_serial_read_mode_ctrl.sv
// serial read-mode selection, shifter and daisy chain of the converter output port
// Overview of operation
// - parallel interface settings drive the shared pin as result bit nine
// - serial master mode takes read-during-convert pin as read mode select
// - read during convert shifts the previous result while converting
// - read during convert uses a longer serial clock period than after convert
// - read after convert shifts the current result only once conversion ends
// - serial slave mode shifts the chain input in behind the result
// - chain level reaches the serial output one result word of host clock falls later
`timescale 1ns/10ps
module adc_serial_read_mode_ctrl
   import adc_serial_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // interface and clock source straps
   input wire logic [1:0] MODE_SELECT,
   input wire logic CLOCK_SOURCE_SELECT,
   // shared pin: result bit nine or read-during-convert select
   input wire logic PARALLEL_DATA_BIT_NINE_IN,
   output logic PARALLEL_DATA_BIT_NINE_OUT,
   output logic PARALLEL_DATA_BIT_NINE_OE,
   // conversion engine
   input wire logic CONVERTING,
   input wire logic RESULT_VALID,
   output logic RESULT_READY,
   input wire logic [WORD_BITS-1:0] RESULT_DATA,
   // serial port
   input wire logic SERIAL_CHAIN_INPUT,
   input wire logic HOST_SCLK,
   input wire logic HOST_SELECT_N,
   output logic SCLK_OUT,
   output logic SCLK_OE,
   output logic SERIAL_RESULT_OUTPUT,
   output logic SERIAL_BUSY
);
   // ==========================================
   // pin synchronisers
   logic [6:0] sync1, sync2;
   logic serial, css, read_during_convert_select, chain, hsclk, hsel_n, master, slave;

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync1 <= SYNC_RESET;
         sync2 <= SYNC_RESET;
      end
      else
      begin
         sync1 <= {MODE_SELECT, CLOCK_SOURCE_SELECT, PARALLEL_DATA_BIT_NINE_IN,
                   SERIAL_CHAIN_INPUT, HOST_SCLK, HOST_SELECT_N};
         sync2 <= sync1;
      end
   end

   assign serial = (sync2[6:5] == MODE_SERIAL);
   assign css = sync2[4];
   assign read_during_convert_select = sync2[3];
   assign chain = sync2[2];
   assign hsclk = sync2[1];
   assign hsel_n = sync2[0];
   assign master = serial && !css;
   assign slave = serial && css;

   // ==========================================
   // result buffer
   logic fifo_valid, pop;
   logic [WORD_BITS-1:0] fifo_word;

   result_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(CLOCK),
      .rst_n(RST_N),
      .in_valid(RESULT_VALID),
      .in_ready(RESULT_READY),
      .in_data(RESULT_DATA),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_word)
   );

   // ==========================================
   // transfer control
   state_t state, next_state;
   logic [WORD_BITS-1:0] shreg, next_shreg, par_word, next_par_word;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [3:0] div_cnt, next_div_cnt, half;
   logic conv_d, hsclk_d, hsel_d, run_rdc, next_run_rdc, run_slave, next_run_slave;
   logic next_sclk, next_serial_result_output, next_bit9_out;
   logic start_master, start_slave, host_fall, conv_rise;

   always_comb
   begin
      next_state = state;
      next_shreg = shreg;
      next_par_word = par_word;
      next_bit_cnt = bit_cnt;
      next_div_cnt = div_cnt;
      next_run_rdc = run_rdc;
      next_run_slave = run_slave;
      next_sclk = SCLK_OUT;
      pop = 1'b0;
      conv_rise = CONVERTING && !conv_d;
      host_fall = hsclk_d && !hsclk;
      half = run_rdc ? RDC_HALF_CYC : RAC_HALF_CYC;
      start_master = (state == ST_IDLE) && master && fifo_valid && (read_during_convert_select ? conv_rise : !CONVERTING);
      start_slave = (state == ST_IDLE) && slave && hsel_d && !hsel_n;
      unique case (state)
         ST_IDLE:
         begin
            next_sclk = 1'b0;
            next_bit_cnt = '0;
            next_div_cnt = '0;
            if (start_master)
            begin
               pop = 1'b1;
               next_shreg = fifo_word;
               next_run_rdc = read_during_convert_select;
               next_run_slave = 1'b0;
               next_state = ST_SHIFT;
            end
            else if (start_slave)
            begin
               // empty buffer shifts zeros rather than stalling the host
               pop = fifo_valid;
               next_shreg = fifo_valid ? fifo_word : WORD_RESET;
               next_run_rdc = 1'b0;
               next_run_slave = 1'b1;
               next_state = ST_SHIFT;
            end
            else if (!serial && fifo_valid)
            begin
               pop = 1'b1;
               next_par_word = fifo_word;
            end
         end
         ST_SHIFT:
         begin
            if (run_slave)
            begin
               if (hsel_n)
                  next_state = ST_DONE;
               else if (host_fall)
                  next_shreg = {shreg[WORD_BITS-2:0], chain};
            end
            else if (div_cnt == half - 4'h1)
            begin
               next_div_cnt = '0;
               next_sclk = !SCLK_OUT;
               if (SCLK_OUT)
               begin
                  if (bit_cnt == LAST_BIT)
                     next_state = ST_DONE;
                  else
                  begin
                     next_bit_cnt = bit_cnt + 5'h01;
                     next_shreg = {shreg[WORD_BITS-2:0], 1'b0};
                  end
               end
            end
            else
               next_div_cnt = div_cnt + 4'h1;
         end
         ST_DONE:
         begin
            next_sclk = 1'b0;
            next_state = ST_IDLE;
         end
      endcase
      next_serial_result_output = (next_state == ST_SHIFT) && next_shreg[WORD_BITS-1];
      next_bit9_out = next_par_word[BIT_NINE_POS];
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state <= ST_IDLE;
         shreg <= WORD_RESET;
         par_word <= WORD_RESET;
         bit_cnt <= '0;
         div_cnt <= '0;
         run_rdc <= 1'b0;
         run_slave <= 1'b0;
         conv_d <= 1'b0;
         hsclk_d <= 1'b0;
         hsel_d <= 1'b1;
         SCLK_OUT <= 1'b0;
         SCLK_OE <= 1'b0;
         SERIAL_RESULT_OUTPUT <= 1'b0;
         SERIAL_BUSY <= 1'b0;
         PARALLEL_DATA_BIT_NINE_OUT <= 1'b0;
         PARALLEL_DATA_BIT_NINE_OE <= 1'b0;
      end
      else
      begin
         state <= next_state;
         shreg <= next_shreg;
         par_word <= next_par_word;
         bit_cnt <= next_bit_cnt;
         div_cnt <= next_div_cnt;
         run_rdc <= next_run_rdc;
         run_slave <= next_run_slave;
         conv_d <= CONVERTING;
         hsclk_d <= hsclk;
         hsel_d <= hsel_n;
         SCLK_OUT <= next_sclk;
         SCLK_OE <= master;
         SERIAL_RESULT_OUTPUT <= next_serial_result_output;
         SERIAL_BUSY <= (next_state != ST_IDLE);
         PARALLEL_DATA_BIT_NINE_OUT <= next_bit9_out;
         PARALLEL_DATA_BIT_NINE_OE <= !serial;
      end
   end

   // ==========================================
   // checks
   AST_BIT_NINE_OE: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !serial |=> PARALLEL_DATA_BIT_NINE_OE) else $error("bit nine not driven in parallel mode");
   AST_BIT_NINE_DATA: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (!serial && pop) |=> PARALLEL_DATA_BIT_NINE_OUT == $past(fifo_word[BIT_NINE_POS]))
      else $error("bit nine does not follow result");
   AST_RDC_START: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state == ST_IDLE && master && read_during_convert_select && conv_rise && fifo_valid) |=> (state == ST_SHIFT && run_rdc))
      else $error("read during convert did not start");
   AST_RDC_DURING_CONV: assert property (@(posedge CLOCK) disable iff (!RST_N)
      ($rose(state == ST_SHIFT) && !run_slave && run_rdc) |-> $past(conv_rise))
      else $error("previous result not shifted at conversion start");
   AST_RDC_PERIOD: assert property (@(posedge CLOCK) disable iff (!RST_N)
      ($rose(SCLK_OUT) && run_rdc) |-> SCLK_OUT[*3] ##1 !SCLK_OUT) else $error("read during convert sclk period");
   AST_RAC_PERIOD: assert property (@(posedge CLOCK) disable iff (!RST_N)
      ($rose(SCLK_OUT) && !run_rdc) |-> SCLK_OUT[*2] ##1 !SCLK_OUT) else $error("read after convert sclk period");
   AST_RAC_WAIT: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state == ST_IDLE && master && !read_during_convert_select && CONVERTING && !start_slave) |=> state == ST_IDLE)
      else $error("read after convert started during conversion");
   AST_CHAIN_IN: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state == ST_SHIFT && run_slave && !hsel_n && host_fall) |=> shreg[0] == $past(chain))
      else $error("chain input not taken");
   AST_CHAIN_OUT: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (state == ST_SHIFT && run_slave && !hsel_n && host_fall) |=> SERIAL_RESULT_OUTPUT == $past(shreg[WORD_BITS-2]))
      else $error("serial output does not advance the chain");
   AST_SLAVE_NO_CLK: assert property (@(posedge CLOCK) disable iff (!RST_N)
      slave |=> !SCLK_OE) else $error("sclk driven in slave mode");
endmodule

// ### verilog/adc_serial_pkg.sv
// shared constants and types for the serial read-mode controller
package adc_serial_pkg;
   // ==========================================
   // word and pin layout
   localparam int WORD_BITS = 18;
   localparam int BIT_NINE_POS = 9;
   localparam logic [4:0] LAST_BIT = 5'h11;
   localparam logic [1:0] MODE_SERIAL = 2'h3;
   localparam int FIFO_DEPTH = 8;
   // ==========================================
   // serial clock timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int RAC_HALF_NS = 80;
   localparam int RDC_HALF_NS = 120;
   localparam logic [3:0] RAC_HALF_CYC = 4'((RAC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RDC_HALF_CYC = 4'((RDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ==========================================
   // reset values
   // straps read as serial slave until synced, so no pin is driven early
   localparam logic [6:0] SYNC_RESET = 7'h71;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 18'h00000;
   // ==========================================
   // transfer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SHIFT = 3'h2,
      ST_DONE = 3'h4
   } state_t;
endpackage

// ### verilog/result_fifo.sv
// result word fifo with registered input ready
`timescale 1ns/10ps
module result_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic next_in_ready, push, pop;

   // ==========================================
   // pointer and count update
   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? ((wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      // ready registered so the source never sees a combinational path
      next_in_ready = (next_count != FULL_COUNT);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready <= next_in_ready;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
      (count == FULL_COUNT) |-> !in_ready) else $error("fifo ready while full");
endmodule

// ### test/host_reader.sv
// host controller model reading serial results in slave and master modes
`timescale 1ns/10ps
module host_reader
(
   // system clock
   input wire logic clk,
   // serial port
   input wire logic sclk_in,
   input wire logic sdata,
   output logic host_sclk,
   output logic select_n,
   output logic chain
);
   initial
   begin
      host_sclk = 1'b0;
      select_n = 1'b1;
      chain = 1'b0;
   end
   // ==========================================
   // slave frame, clock still outside frames
   // host clocks and frames
   task automatic read_frame(input int nbits, input logic [17:0] pat, output logic [35:0] got);
      #7;
      got = '0;
      select_n = 1'b0;
      for (int k = 0; k < nbits; k++)
      begin
         #160;
         host_sclk = 1'b1;
         got = {got[34:0], sdata};
         // set with the rising edge so the falling edge 160 ns later sees it settled
         chain = pat[17 - (k % 18)];
         #160;
         host_sclk = 1'b0;
      end
      #160;
      select_n = 1'b1;
      chain = ~chain;
      #200;
   endtask
   // ==========================================
   // master capture on rising serial clock
   task automatic capture(output logic [17:0] word, output int period, output bit ok);
      int n;
      int t0;
      int bits;
      logic prev;
      n = 0;
      t0 = 0;
      bits = 0;
      period = 0;
      word = '0;
      prev = sclk_in;
      while (bits < 18 && n < 2000)
      begin
         @(posedge clk);
         n++;
         if (sclk_in && !prev)
         begin
            word = {word[16:0], sdata};
            if (bits == 1)
               period = n - t0;
            t0 = n;
            bits++;
         end
         prev = sclk_in;
      end
      ok = (bits == 18);
   endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the serial read-mode controller
`timescale 1ns/10ps
module tb_top;
   import adc_serial_pkg::*;
   logic clock, rst_n, css, read_during_convert_select, converting, result_valid, result_ready, bit9_out, oe, pin_nine;
   logic host_sclk, host_select_n, chain, sclk_out, sclk_oe, serial_result_output, busy;
   logic [1:0] mode_select;
   logic [17:0] result_data;
   int errors;
   int num_checks;
   // shared pin level: device drives it in parallel modes
   assign pin_nine = oe ? bit9_out : read_during_convert_select;
   adc_serial_read_mode_ctrl uut (.CLOCK(clock), .RST_N(rst_n), .MODE_SELECT(mode_select),
      .CLOCK_SOURCE_SELECT(css), .PARALLEL_DATA_BIT_NINE_IN(pin_nine), .PARALLEL_DATA_BIT_NINE_OUT(bit9_out),
      .PARALLEL_DATA_BIT_NINE_OE(oe), .CONVERTING(converting), .RESULT_VALID(result_valid),
      .RESULT_READY(result_ready), .RESULT_DATA(result_data), .SERIAL_CHAIN_INPUT(chain),
      .HOST_SCLK(host_sclk), .HOST_SELECT_N(host_select_n), .SCLK_OUT(sclk_out), .SCLK_OE(sclk_oe),
      .SERIAL_RESULT_OUTPUT(serial_result_output), .SERIAL_BUSY(busy));
   host_reader host (.clk(clock), .sclk_in(sclk_out), .sdata(serial_result_output), .host_sclk(host_sclk),
      .select_n(host_select_n), .chain(chain));
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   function automatic logic [17:0] wd(input int i);
      return 18'(18'h1A2B3 + i * 18'h0F3D1);
   endfunction
   // ==========================================
   // checking and closing
   task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // result push, entered and left at a rising edge
   task automatic push(input logic [17:0] w, input int limit, output bit taken);
      int n;
      n = 0;
      result_valid <= 1'b1;
      result_data <= w;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (!result_ready && n < limit);
      taken = result_ready;
      result_valid <= 1'b0;
      // one idle edge so the next push never re-raises valid in this step
      @(posedge clock);
   endtask
   task automatic put(input logic [17:0] w);
      bit t;
      push(w, 20, t);
      check(36'(t), 36'h1, "word accepted");
      if (!t)
         stop_test;
   endtask
   // ==========================================
   // scenarios
   task automatic test_slave;
      bit t;
      logic [35:0] got;
      for (int i = 0; i < FIFO_DEPTH; i++)
         put(wd(i));
      push(18'h3FFFF, 5, t);
      check(36'(t), 36'h0, "full buffer refuses");
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
         host.read_frame(36, wd(i + 20), got);
         @(posedge clock);
         check(got, {wd(i), wd(i + 20)}, "slave word then chain");
         check(36'(sclk_oe), 36'h0, "host owns clock");
      end
      host.read_frame(18, 18'h0, got);
      @(posedge clock);
      check(got, 36'h0, "empty buffer reads zeros");
      $display("test slave done");
   endtask
   task automatic test_parallel;
      logic [17:0] w;
      mode_select <= 2'h0;
      repeat (6) @(posedge clock);
      for (int i = 0; i < 3; i++)
      begin
         // walk all three parallel settings
         mode_select <= 2'(i);
         w = (i == 1) ? 18'h3FDFF : 18'h00200;
         put(w);
         repeat (6) @(posedge clock);
         check({35'h0, bit9_out}, {35'h0, w[BIT_NINE_POS]}, "bit nine");
         check(36'(oe), 36'h1, "pin driven");
      end
      mode_select <= MODE_SERIAL;
      repeat (6) @(posedge clock);
      check(36'(oe), 36'h0, "pin released");
      $display("test parallel done");
   endtask
   task automatic read_master(input logic [17:0] w, input logic [3:0] half);
      logic [17:0] got;
      int per;
      bit ok;
      host.capture(got, per, ok);
      check(36'(ok), 36'h1, "serial clock seen");
      if (!ok)
         stop_test;
      check(36'(got), 36'(w), "master word");
      check(36'(per), 36'(2 * half), "clock period");
      repeat (8) @(posedge clock);
   endtask
   task automatic test_master;
      css <= 1'b0;
      read_during_convert_select <= 1'b0;
      converting <= 1'b1;
      repeat (6) @(posedge clock);
      check(36'(sclk_oe), 36'h1, "master drives clock");
      put(wd(9));
      repeat (8) @(posedge clock);
      check(36'(busy), 36'h0, "waits for conversion end");
      converting <= 1'b0;
      read_master(wd(9), RAC_HALF_CYC);
      read_during_convert_select <= 1'b1;
      repeat (6) @(posedge clock);
      put(wd(10));
      repeat (8) @(posedge clock);
      check(36'(busy), 36'h0, "waits for next conversion");
      converting <= 1'b1;
      read_master(wd(10), RDC_HALF_CYC);
      converting <= 1'b0;
      $display("test master done");
   endtask
   initial
   begin
      errors = 0;
      num_checks = 0;
      rst_n = 1'b0;
      mode_select = MODE_SERIAL;
      css = 1'b1;
      read_during_convert_select = 1'b0;
      converting = 1'b0;
      result_valid = 1'b0;
      result_data = '0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      test_slave;
      test_parallel;
      test_master;
      stop_test;
   end
endmodule
